//--- rtl/chgrb_map.vh
// chgrb_map.vh: register map, field positions, reset values, timing counts
// assumes: included by the charger register bank, 40 MHz core clock
`ifndef CHGRB_MAP_VH
`define CHGRB_MAP_VH

// target address on the two-wire bus
`define CHGRB_DEV_ADDR      7'h6b

// register offsets
`define CHGRB_A_ICL         4'h0
`define CHGRB_A_CTL1        4'h1
`define CHGRB_A_CCL         4'h2
`define CHGRB_A_PTC         4'h3
`define CHGRB_A_BVL         4'h4
`define CHGRB_A_CTL2        4'h5
`define CHGRB_A_CTL3        4'h6
`define CHGRB_A_CTL4        4'h7
`define CHGRB_A_STS1        4'h8
`define CHGRB_A_FLT         4'h9
`define CHGRB_A_STS2        4'ha
`define CHGRB_A_PART        4'hb
`define CHGRB_A_CTL5        4'hc
`define CHGRB_A_LAST        8'h0c

// reset values
`define CHGRB_R_ICL         8'h17
`define CHGRB_R_CTL1        8'h1a
`define CHGRB_R_CCL         8'h91
`define CHGRB_R_PTC         8'h12
`define CHGRB_R_BVL         8'h40
`define CHGRB_R_CTL2        8'h9e
`define CHGRB_R_CTL3        8'he6
`define CHGRB_R_CTL4        8'h4c
`define CHGRB_R_CTL5        8'h00
// arbitrary part information value
`define CHGRB_R_PART        8'h00
`define CHGRB_UNMAPPED      8'hff

// bits that return to default on watchdog expiry
`define CHGRB_WM_ICL        8'h80
`define CHGRB_WM_CTL1       8'h70
`define CHGRB_WM_CCL        8'hbf
`define CHGRB_WM_PTC        8'hff
`define CHGRB_WM_BVL        8'hff
`define CHGRB_WM_CTL2       8'hff
`define CHGRB_WM_CTL3       8'h00
`define CHGRB_WM_CTL4       8'hc4
`define CHGRB_WM_CTL5       8'h00

// field positions
`define CHGRB_B_HIZ         7
`define CHGRB_B_TSIGN       6
`define CHGRB_B_WDRST       6
`define CHGRB_B_BSTEN       5
`define CHGRB_B_CHGEN       4
`define CHGRB_B_FULLON      6
`define CHGRB_B_WDFLT       7
`define CHGRB_B_WDT_HI      5
`define CHGRB_B_WDT_LO      4

// source-detect limit codes: 500 mA, 1.5 A, 2.4 A
`define CHGRB_ICL_500       5'h04
`define CHGRB_ICL_1500      5'h0e
`define CHGRB_ICL_2400      5'h17
`define CHGRB_FAST_CHARGE_CURRENT_CODE_MAX      6'h32
`define CHGRB_IPRE_MAX      4'hc
// code 6 = 700 mA
`define CHGRB_ICL_700       5'h06

// watchdog timing: one tick per second
`define CHGRB_CLK_HZ        40000000
`define CHGRB_WD_UNIT_S     40
// watchdog limits in seconds
`define CHGRB_WD_40S        8'h28
`define CHGRB_WD_80S        8'h50
`define CHGRB_WD_160S       8'ha0
`endif

//--- rtl/chgrb_bank.v
// chgrb_bank.v: charger register bank with two-wire target and watchdog
// assumes: scl/sda arrive unsynchronised, open-drain pad outside
//
// Overview of operation
// - burst reads and writes accepted from any register 00h to 0Ch.
// - fault register and status2 bits 6..4 latch changes until read.
// - watchdog-expired bit high in default mode, low in host mode.
// - power-on gives default mode, watchdog expired, all fields default.
// - target answers at 7-bit address 6Bh.
// - watchdog-resettable fields default on reset command and on expiry.
// - thermistor ignore forces condition good and fault field 000.
// - input limit code 5 bits, 100 mA offset, default 10111.
// - source detection overwrites input limit with 500 mA, 1.5 A, 2.4 A.
// - charging only if pin low, enable bit set, current nonzero.
// - boost and charge bits both set allow automatic mode change.
// - minimum system voltage code 3 bits, default 101.
// - boost threshold select bit chooses exit and start thresholds.
// - boost current limit bit, default 1 for 1.2 A.
// - input blocker fully on in boost or above 700 mA, else bit.
// - fast charge code 6 bits, zero disables, clamped to 110010.
// - precharge code bits 7..4, clamped to 1100.
// - termination code bits 3..0, default 0010.
// - battery voltage code bits 7..3, default 01000.
// - reads above last register return FFh.
// - undefined register address gets not-acknowledge, back to idle.
// - watchdog timeout 00 off, 01 40 s, 10 80 s, 11 160 s.
`timescale 1ns/1ps
`include "chgrb_map.vh"

module chgrb_bank
#(
   parameter TICK_CYC = 40000000
)
(
   // clock and reset
   input  wire       clk_i,
   input  wire       arst_n_i,
   // two-wire bus, open drain
   input  wire       scl_i,
   input  wire       sda_i,
   output wire       sda_o,
   output wire       sda_oe_n_o,
   // analog side status
   input  wire       reg_reset_i,
   input  wire       charge_dis_n_i,
   input  wire       adapter_i,
   input  wire       therm_good_i,
   input  wire [7:0] status1_i,
   input  wire [7:0] fault_i,
   input  wire [7:0] status2_i,
   input  wire       det_done_i,
   input  wire [1:0] det_type_i,
   // controls to the regulation loops
   output reg        charge_en_o,
   output reg        boost_en_o,
   output reg        blocker_full_on_o,
   output reg        host_mode_o,
   output reg  [4:0] icl_code_o,
   output reg  [5:0] fast_charge_current_code_code_o,
   output reg  [3:0] ipre_code_o
);

   // -----------------------------------------------------------------
   // helper functions
   // -----------------------------------------------------------------
   function [7:0] dflt;
      input [3:0] a;
      begin
         case (a)
            `CHGRB_A_ICL  : dflt = `CHGRB_R_ICL;
            `CHGRB_A_CTL1 : dflt = `CHGRB_R_CTL1;
            `CHGRB_A_CCL  : dflt = `CHGRB_R_CCL;
            `CHGRB_A_PTC  : dflt = `CHGRB_R_PTC;
            `CHGRB_A_BVL  : dflt = `CHGRB_R_BVL;
            `CHGRB_A_CTL2 : dflt = `CHGRB_R_CTL2;
            `CHGRB_A_CTL3 : dflt = `CHGRB_R_CTL3;
            `CHGRB_A_CTL4 : dflt = `CHGRB_R_CTL4;
            default       : dflt = `CHGRB_R_CTL5;
         endcase
      end
   endfunction

   function [7:0] wmask;
      input [3:0] a;
      begin
         case (a)
            `CHGRB_A_ICL  : wmask = `CHGRB_WM_ICL;
            `CHGRB_A_CTL1 : wmask = `CHGRB_WM_CTL1;
            `CHGRB_A_CCL  : wmask = `CHGRB_WM_CCL;
            `CHGRB_A_PTC  : wmask = `CHGRB_WM_PTC;
            `CHGRB_A_BVL  : wmask = `CHGRB_WM_BVL;
            `CHGRB_A_CTL2 : wmask = `CHGRB_WM_CTL2;
            `CHGRB_A_CTL3 : wmask = `CHGRB_WM_CTL3;
            `CHGRB_A_CTL4 : wmask = `CHGRB_WM_CTL4;
            default       : wmask = `CHGRB_WM_CTL5;
         endcase
      end
   endfunction

   // map physical offset to storage slot for writable registers
   function [3:0] slot;
      input [3:0] a;
      begin
         slot = (a == `CHGRB_A_CTL5) ? 4'h8 : a;
      end
   endfunction

   function writable;
      input [7:0] a;
      begin
         writable = (a <= 8'h07) || (a == `CHGRB_A_LAST);
      end
   endfunction

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   reg [2:0] scl_s_q;
   reg [2:0] sda_s_q;
   reg [2:0] ce_s_q;
   reg       scl_q;
   reg       sda_q;
   reg       ce_q;

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         ce_s_q  <= 3'h7;
         ce_q    <= 1'b1;
      end
      else
      begin
         scl_s_q <= {scl_s_q[1:0], scl_i};
         sda_s_q <= {sda_s_q[1:0], sda_i};
         if (scl_s_q[1] == scl_s_q[2])
            scl_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2])
            sda_q <= sda_s_q[2];
         ce_s_q  <= {ce_s_q[1:0], charge_dis_n_i};
         if (ce_s_q[1] == ce_s_q[2])
            ce_q <= ce_s_q[2];
      end
   end

   wire scl_new = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
   wire sda_new = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
   wire ce_new  = (ce_s_q[1] == ce_s_q[2]) ? ce_s_q[2] : ce_q;
   wire scl_rise = scl_new & ~scl_q;
   wire scl_fall = ~scl_new & scl_q;
   wire start_c  = scl_new & scl_q & sda_q & ~sda_new;
   wire stop_c   = scl_new & scl_q & ~sda_q & sda_new;

   // -----------------------------------------------------------------
   // bus target state machine
   // -----------------------------------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_REG  = 3'h2;
   localparam ST_WDAT = 3'h3;
   localparam ST_RDAT = 3'h4;
   localparam ST_ACK  = 3'h5;
   localparam ST_MACK = 3'h6;

   reg [2:0] st_q;
   reg [2:0] nxt_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg [7:0] ptr_q;
   reg       drv_q;
   reg       rd_q;

   reg [7:0] ctl_q [0:8];
   reg [7:0] flt_q;
   reg [2:0] st2_q;
   reg       wd_flt_q;
   reg       wd_kick;
   reg       wr_stb;
   reg       rd_flt;
   reg       rd_st2;

   // -----------------------------------------------------------------
   // live status and read mux
   // -----------------------------------------------------------------
   reg [7:0] rdata;
   wire [7:0] flt_view;
   assign flt_view = {wd_flt_q, flt_q[6:3],
                      ctl_q[0][`CHGRB_B_TSIGN] ? 3'h0 : flt_q[2:0]};

   always @*
   begin
      rdata = `CHGRB_UNMAPPED;
      if (ptr_q <= 8'h07 || ptr_q == `CHGRB_A_LAST)
         rdata = ctl_q[slot(ptr_q[3:0])];
      if (ptr_q == {4'h0, `CHGRB_A_CTL1})
         rdata[`CHGRB_B_WDRST] = 1'b0;
      if (ptr_q == {4'h0, `CHGRB_A_STS1})
         rdata = status1_i;
      if (ptr_q == {4'h0, `CHGRB_A_FLT})
         rdata = flt_view;
      if (ptr_q == {4'h0, `CHGRB_A_STS2})
         rdata = {status2_i[7], st2_q, status2_i[3:0]};
      if (ptr_q == {4'h0, `CHGRB_A_PART})
         rdata = `CHGRB_R_PART;
      if (ptr_q > `CHGRB_A_LAST)
         rdata = `CHGRB_UNMAPPED;
   end

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_q  <= ST_IDLE;
         nxt_q <= ST_IDLE;
         bit_q <= 4'h0;
         sh_q  <= 8'h00;
         ptr_q <= 8'h00;
         drv_q <= 1'b0;
         rd_q  <= 1'b0;
      end
      else if (start_c)
      begin
         st_q  <= ST_ADDR;
         bit_q <= 4'h0;
         drv_q <= 1'b0;
      end
      else if (stop_c)
      begin
         st_q  <= ST_IDLE;
         drv_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            ST_ADDR, ST_REG, ST_WDAT:
            begin
               if (scl_rise)
               begin
                  sh_q  <= {sh_q[6:0], sda_new};
                  bit_q <= bit_q + 4'h1;
               end
               if (scl_fall && bit_q == 4'h8)
               begin
                  bit_q <= 4'h0;
                  st_q  <= ST_ACK;
                  drv_q <= 1'b1;
                  case (st_q)
                     ST_ADDR:
                     begin
                        if (sh_q[7:1] != `CHGRB_DEV_ADDR)
                        begin
                           st_q  <= ST_IDLE;
                           drv_q <= 1'b0;
                        end
                        rd_q  <= sh_q[0];
                        nxt_q <= sh_q[0] ? ST_RDAT : ST_REG;
                     end
                     ST_REG:
                     begin
                        if (sh_q > `CHGRB_A_LAST)
                        begin
                           st_q  <= ST_IDLE;
                           drv_q <= 1'b0;
                        end
                        ptr_q <= sh_q;
                        nxt_q <= ST_WDAT;
                     end
                     default:
                     begin
                        ptr_q <= ptr_q + 8'h01;
                        nxt_q <= ST_WDAT;
                     end
                  endcase
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  st_q  <= nxt_q;
                  sh_q  <= rdata;
                  drv_q <= (nxt_q == ST_RDAT) ? ~rdata[7] : 1'b0;
                  bit_q <= (nxt_q == ST_RDAT) ? 4'h1 : 4'h0;
               end
            end
            ST_RDAT:
            begin
               if (scl_fall)
               begin
                  if (bit_q == 4'h8)
                  begin
                     drv_q <= 1'b0;
                     st_q  <= ST_MACK;
                     ptr_q <= ptr_q + 8'h01;
                  end
                  else
                  begin
                     drv_q <= ~sh_q[7 - bit_q[2:0]];
                     bit_q <= bit_q + 4'h1;
                  end
               end
            end
            ST_MACK:
            begin
               if (scl_rise)
                  st_q <= sda_new ? ST_IDLE : ST_ACK;
               nxt_q <= ST_RDAT;
            end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   // active-low enable: pin pulled low while drv_q
   assign sda_o      = 1'b0;
   assign sda_oe_n_o = ~drv_q;

   always @*
   begin
      wr_stb = (st_q == ST_WDAT) && scl_fall && bit_q == 4'h8 && !start_c && !stop_c;
      rd_flt = (st_q == ST_ACK) && scl_fall && nxt_q == ST_RDAT
               && ptr_q == {4'h0, `CHGRB_A_FLT};
      rd_st2 = (st_q == ST_ACK) && scl_fall && nxt_q == ST_RDAT
               && ptr_q == {4'h0, `CHGRB_A_STS2};
      wd_kick = wr_stb && ptr_q == {4'h0, `CHGRB_A_CTL1} && sh_q[`CHGRB_B_WDRST];
   end

   // -----------------------------------------------------------------
   // watchdog, 1 s tick
   // -----------------------------------------------------------------
   reg [25:0] tick_q;
   reg [7:0]  sec_q;
   wire       tick = (tick_q == TICK_CYC[25:0] - 26'h1);
   wire [1:0] wdt  = ctl_q[5][`CHGRB_B_WDT_HI:`CHGRB_B_WDT_LO];
   reg  [7:0] wd_lim;
   wire       wd_exp;

   always @*
   begin
      case (wdt)
         2'h1    : wd_lim = `CHGRB_WD_40S;
         2'h2    : wd_lim = `CHGRB_WD_80S;
         2'h3    : wd_lim = `CHGRB_WD_160S;
         default : wd_lim = 8'h00;
      endcase
   end

   assign wd_exp = tick && !wd_flt_q && wdt != 2'h0 && sec_q == wd_lim - 8'h01;

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         tick_q <= 26'h0;
         sec_q  <= 8'h00;
      end
      else if (wd_kick || wdt == 2'h0 || wd_flt_q)
      begin
         tick_q <= 26'h0;
         sec_q  <= 8'h00;
      end
      else
      begin
         tick_q <= tick ? 26'h0 : tick_q + 26'h1;
         if (tick)
            sec_q <= sec_q + 8'h01;
      end
   end

   // -----------------------------------------------------------------
   // register storage
   // -----------------------------------------------------------------
   integer i;
   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         for (i = 0; i < 9; i = i + 1)
            ctl_q[i] <= dflt((i == 8) ? `CHGRB_A_CTL5 : i[3:0]);
         wd_flt_q <= 1'b1;
         flt_q    <= 8'h00;
         st2_q    <= 3'h0;
      end
      else
      begin
         flt_q <= (rd_flt ? 8'h00 : flt_q) | fault_i;
         st2_q <= (rd_st2 ? 3'h0 : st2_q) | status2_i[6:4];
         if (wd_exp)
            wd_flt_q <= 1'b1;
         else if (wd_kick)
            wd_flt_q <= 1'b0;
         for (i = 0; i < 9; i = i + 1)
         begin
            if (reg_reset_i)
               ctl_q[i] <= dflt((i == 8) ? `CHGRB_A_CTL5 : i[3:0]);
            else if (wd_exp)
               ctl_q[i] <= (ctl_q[i] & ~wmask((i == 8) ? `CHGRB_A_CTL5 : i[3:0]))
                         | (dflt((i == 8) ? `CHGRB_A_CTL5 : i[3:0])
                            & wmask((i == 8) ? `CHGRB_A_CTL5 : i[3:0]));
         end
         if (!reg_reset_i && !wd_exp && wr_stb && writable(ptr_q))
         begin
            ctl_q[slot(ptr_q[3:0])] <= sh_q;
            if (ptr_q == {4'h0, `CHGRB_A_CCL} && sh_q[5:0] > `CHGRB_FAST_CHARGE_CURRENT_CODE_MAX)
               ctl_q[2] <= {sh_q[7:6], `CHGRB_FAST_CHARGE_CURRENT_CODE_MAX};
            if (ptr_q == {4'h0, `CHGRB_A_PTC} && sh_q[7:4] > `CHGRB_IPRE_MAX)
               ctl_q[3] <= {`CHGRB_IPRE_MAX, sh_q[3:0]};
         end
         if (!reg_reset_i && det_done_i)
         begin
            case (det_type_i)
               2'h1    : ctl_q[0][4:0] <= `CHGRB_ICL_1500;
               2'h2    : ctl_q[0][4:0] <= `CHGRB_ICL_2400;
               default : ctl_q[0][4:0] <= `CHGRB_ICL_500;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // control outputs
   // -----------------------------------------------------------------
   wire ts_ok = ctl_q[0][`CHGRB_B_TSIGN] | therm_good_i;
   wire chg_ok = !ce_new && ctl_q[1][`CHGRB_B_CHGEN] && ctl_q[2][5:0] != 6'h00;
   wire bst_ok = ctl_q[1][`CHGRB_B_BSTEN];

   always @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         charge_en_o       <= 1'b0;
         boost_en_o        <= 1'b0;
         blocker_full_on_o <= 1'b0;
         host_mode_o       <= 1'b0;
         icl_code_o        <= 5'h17;
         fast_charge_current_code_code_o       <= 6'h11;
         ipre_code_o       <= 4'h1;
      end
      else
      begin
         charge_en_o <= chg_ok && ts_ok && adapter_i && !ctl_q[0][`CHGRB_B_HIZ];
         boost_en_o  <= bst_ok && ts_ok && !adapter_i;
         blocker_full_on_o <= (bst_ok && !adapter_i) ||
                              ctl_q[0][4:0] > `CHGRB_ICL_700 ||
                              ctl_q[2][`CHGRB_B_FULLON];
         host_mode_o <= !wd_flt_q;
         icl_code_o  <= ctl_q[0][4:0];
         fast_charge_current_code_code_o <= ctl_q[2][5:0];
         ipre_code_o <= ctl_q[3][7:4];
      end
   end

endmodule

//--- verification/chgrb_bank_asserts.sv
// chgrb_bank_asserts.sv: port checks of the charger register bank
// assumes: bound to chgrb_bank, tick length handed on by the bind
`timescale 1ns/1ps
module chgrb_chk
#(
   parameter TICK_CYC = 40000000
)
(
   // clock, reset, side inputs
   input wire       clk_i,
   input wire       arst_n_i,
   input wire       reg_reset_i,
   input wire       charge_dis_n_i,
   input wire       det_done_i,
   input wire [1:0] det_type_i,
   // controls
   input wire       charge_en_o,
   input wire       boost_en_o,
   input wire       blocker_full_on_o,
   input wire       host_mode_o,
   input wire [4:0] icl_code_o,
   input wire [5:0] fast_charge_current_code_code_o,
   input wire [3:0] ipre_code_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_dflt;
      icl_code_o == 5'h17 && fast_charge_current_code_code_o == 6'h11 && ipre_code_o == 4'h1;
   endsequence
   sequence s_wd_dflt;
      fast_charge_current_code_code_o == 6'h11 && ipre_code_o == 4'h1;
   endsequence
   property p_rst;
      $rose(arst_n_i) |-> s_dflt ##1 !host_mode_o;
   endproperty
   property p_regrst;
      reg_reset_i |-> ##[1:3] s_dflt;
   endproperty
   property p_wdexp;
      $fell(host_mode_o) |-> ##[0:2] s_wd_dflt;
   endproperty
   property p_det;
      det_done_i |-> ##[1:4] icl_code_o == ((det_type_i == 2'h1) ? 5'h0e :
                                            (det_type_i == 2'h2) ? 5'h17 : 5'h04);
   endproperty
   property p_fast_charge_current_code;
      fast_charge_current_code_code_o <= 6'h32;
   endproperty
   property p_ipre;
      ipre_code_o <= 4'hc;
   endproperty
   property p_fullon;
      (icl_code_o > 5'h06 || boost_en_o) [*2] |-> blocker_full_on_o;
   endproperty
   property p_pin;
      charge_dis_n_i [*5] |-> !charge_en_o;
   endproperty
   property p_zero;
      (fast_charge_current_code_code_o == 6'h00) [*3] |-> !charge_en_o;
   endproperty
   a_rst: assert property (p_rst) else $error("defaults wrong after reset");
   a_regrst: assert property (p_regrst) else $error("register reset ignored");
   a_wdexp: assert property (p_wdexp) else $error("expiry kept fields");
   a_det: assert property (p_det) else $error("detect limit wrong");
   a_fast_charge_current_code: assert property (p_fast_charge_current_code) else $error("charge code not clamped");
   a_ipre: assert property (p_ipre) else $error("precharge not clamped");
   a_fullon: assert property (p_fullon) else $error("blocker not full on");
   a_pin: assert property (p_pin) else $error("charging with pin high");
   a_zero: assert property (p_zero) else $error("charging at zero code");
endmodule
bind chgrb_bank chgrb_chk #(.TICK_CYC(TICK_CYC)) chgrb_chk_inst (.clk_i(clk_i),
   .arst_n_i(arst_n_i), .reg_reset_i(reg_reset_i), .charge_dis_n_i(charge_dis_n_i),
   .det_done_i(det_done_i), .det_type_i(det_type_i), .charge_en_o(charge_en_o),
   .boost_en_o(boost_en_o), .blocker_full_on_o(blocker_full_on_o),
   .host_mode_o(host_mode_o), .icl_code_o(icl_code_o), .fast_charge_current_code_code_o(fast_charge_current_code_code_o),
   .ipre_code_o(ipre_code_o));

//--- verification/chgrb_host.sv
// chgrb_host.sv: two-wire bus controller model, 200 ns bit period
// assumes: open-drain bus with pull-up resolved in the bench
`timescale 1ns/1ps
`include "chgrb_map.vh"
module chgrb_host
(
   // bus pins, release high
   output logic scl_o,
   output logic sda_rel_o,
   input  wire  sda_i
);
   initial
   begin
      scl_o = 1'b1;
      sda_rel_o = 1'b1;
   end
   // data changes only while clock low
   task automatic bo(input logic b);
      #50 sda_rel_o = b;
      #50 scl_o = 1'b1;
      #100 scl_o = 1'b0;
   endtask
   task automatic bi(output logic b);
      #50 sda_rel_o = 1'b1;
      #50 scl_o = 1'b1;
      #50 b = sda_i;
      #50 scl_o = 1'b0;
   endtask
   task automatic st;
      #50 sda_rel_o = 1'b1;
      #50 scl_o = 1'b1;
      #50 sda_rel_o = 1'b0;
      #50 scl_o = 1'b0;
   endtask
   task automatic sp;
      #50 sda_rel_o = 1'b0;
      #50 scl_o = 1'b1;
      #50 sda_rel_o = 1'b1;
      #100;
   endtask
   task automatic wb(input logic [7:0] d, inout logic ok);
      logic a;
      for (int i = 7; i >= 0; i--)
         bo(d[i]);
      bi(a);
      ok = ok & ~a;
   endtask
   task automatic wr(input logic [6:0] dv, input logic [7:0] ra,
                     input logic [7:0] d[$], output logic ok);
      #7;
      ok = 1'b1;
      st();
      wb({dv, 1'b0}, ok);
      if (ok) wb(ra, ok);
      foreach (d[i]) if (ok) wb(d[i], ok);
      sp();
   endtask
   task automatic rd(input logic [7:0] ra, input int n, output logic [7:0] q[$]);
      logic ok;
      logic [7:0] b;
      #7;
      ok = 1'b1;
      q = {};
      st();
      wb({`CHGRB_DEV_ADDR, 1'b0}, ok);
      wb(ra, ok);
      st();
      wb({`CHGRB_DEV_ADDR, 1'b1}, ok);
      for (int k = 0; k < n; k++)
      begin
         for (int i = 7; i >= 0; i--)
            bi(b[i]);
         bo(k == n - 1);
         q.push_back(b);
      end
      sp();
   endtask
endmodule

//--- verification/charger_i2c_register_bank_tb.sv
// charger_i2c_register_bank_tb.sv: self-checking bench of the register bank
// assumes: controller model drives the bus, 40 MHz clock
`timescale 1ns/1ps
`include "chgrb_map.vh"
module charger_i2c_register_bank_tb;
   localparam int TICK = 100;
   logic       clk_i, arst_n_i, reg_reset_i, charge_dis_n_i, adapter_i, therm_good_i;
   logic       det_done_i, ok;
   logic [1:0] det_type_i;
   logic [7:0] status1_i, fault_i, status2_i, r;
   wire        scl, sda_rel, sda_o, sda_oe_n_o, charge_en_o, boost_en_o;
   wire        blocker_full_on_o, host_mode_o;
   wire  [4:0] icl_code_o;
   wire  [5:0] fast_charge_current_code_code_o;
   wire  [3:0] ipre_code_o;
   wire        sda_bus = sda_rel & (sda_oe_n_o | sda_o);
   int         err_total, tests_run, seed;
   chgrb_bank #(.TICK_CYC(TICK)) chgrb_bank_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
      .reg_reset_i(reg_reset_i), .charge_dis_n_i(charge_dis_n_i), .adapter_i(adapter_i),
      .therm_good_i(therm_good_i), .status1_i(status1_i), .fault_i(fault_i),
      .status2_i(status2_i), .det_done_i(det_done_i), .det_type_i(det_type_i),
      .charge_en_o(charge_en_o), .boost_en_o(boost_en_o),
      .blocker_full_on_o(blocker_full_on_o), .host_mode_o(host_mode_o),
      .icl_code_o(icl_code_o), .fast_charge_current_code_code_o(fast_charge_current_code_code_o), .ipre_code_o(ipre_code_o));
   chgrb_host chgrb_host_inst (.scl_o(scl), .sda_rel_o(sda_rel), .sda_i(sda_bus));
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   function automatic logic [4:0] det_exp(input logic [1:0] t);
      return (t == 2'h1) ? 5'h0e : (t == 2'h2) ? 5'h17 : 5'h04;
   endfunction
   function automatic logic fon_exp(input logic [4:0] c, input logic b);
      return (c > 5'h06) ? 1'b1 : b;
   endfunction
   task automatic finish_test;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] ra, input logic [7:0] d[$]);
      logic a;
      chgrb_host_inst.wr(`CHGRB_DEV_ADDR, ra, d, a);
      @(posedge clk_i);
   endtask
   task automatic rc(input logic [7:0] ra, input logic [7:0] exp[$]);
      logic [7:0] q[$];
      chgrb_host_inst.rd(ra, exp.size(), q);
      foreach (exp[i]) chk(q[i], exp[i]);
      @(posedge clk_i);
   endtask
   initial
   begin
      #2000000;
      err_total++;
      finish_test();
   end
   initial
   begin
      seed = 32804;
      {arst_n_i, reg_reset_i, adapter_i, det_done_i, det_type_i} = 6'h08;
      {charge_dis_n_i, therm_good_i, status1_i, fault_i, status2_i} = 26'h3000000;
      cy(2);
      arst_n_i <= 1'b1;
      status1_i <= $random(seed);
      cy(4);
      rc(8'h00, {8'h17, 8'h1a, 8'h91, 8'h12, 8'h40, 8'h9e});
      rc(8'h09, {8'h80});
      charge_dis_n_i <= 1'b0;
      cy(10);
      chk({7'h00, charge_en_o}, 8'h01);
      wr(8'h01, {8'h3a});
      adapter_i <= 1'b0;
      cy(10);
      chk({6'h00, boost_en_o, blocker_full_on_o}, 8'h03);
      adapter_i <= 1'b1;
      cy(10);
      chk({6'h00, boost_en_o, charge_en_o}, 8'h01);
      wr(8'h02, {8'hff});
      rc(8'h02, {8'hf2});
      wr(8'h02, {8'h80});
      cy(10);
      chk({7'h00, charge_en_o}, 8'h00);
      wr(8'h02, {8'h91});
      charge_dis_n_i <= 1'b1;
      cy(10);
      chk({7'h00, charge_en_o}, 8'h00);
      for (int k = 0; k < 4; k++)
      begin
         r = $random(seed);
         if (k < 2) r[4:0] = 5'h06 + k[4:0];
         r[6] = 1'b0;
         wr(8'h00, {r});
         cy(4);
         chk({blocker_full_on_o, icl_code_o}, {fon_exp(r[4:0], 1'b0), r[4:0]});
         rc(8'h00, {r});
      end
      r = $random(seed);
      wr(8'h03, {8'hff, r});
      rc(8'h03, {8'hcf, r});
      chk({4'h0, ipre_code_o}, 8'h0c);
      for (int t = 0; t < 4; t++)
      begin
         det_type_i <= t[1:0];
         det_done_i <= 1'b1;
         cy(1);
         det_done_i <= 1'b0;
         cy(6);
         chk({3'h0, icl_code_o}, {3'h0, det_exp(t[1:0])});
      end
      {fault_i, status2_i} <= 16'h4870;
      cy(4);
      {fault_i, status2_i} <= 16'h0000;
      cy(4);
      rc(8'h09, {8'hc8});
      rc(8'h09, {8'h80});
      rc(8'h0a, {8'h70});
      rc(8'h0a, {8'h00});
      wr(8'h00, {8'h57});
      fault_i <= 8'h05;
      cy(4);
      fault_i <= 8'h00;
      rc(8'h09, {8'h80});
      wr(8'h00, {8'h17});
      chgrb_host_inst.wr(7'h6a, 8'h00, {8'h1f}, ok);
      chk({7'h00, ok}, 8'h00);
      chgrb_host_inst.wr(`CHGRB_DEV_ADDR, 8'h0d, {8'h1f}, ok);
      chk({7'h00, ok}, 8'h00);
      rc(8'h00, {8'h17});
      rc(8'h0b, {`CHGRB_R_PART, `CHGRB_R_CTL5, 8'hff});
      wr(8'h08, {~status1_i});
      rc(8'h08, {status1_i});
      wr(8'h00, {8'h1f});
      reg_reset_i <= 1'b1;
      cy(1);
      reg_reset_i <= 1'b0;
      cy(4);
      chk({3'h0, icl_code_o}, 8'h17);
      wr(8'h01, {8'h5a});
      chk({7'h00, host_mode_o}, 8'h01);
      rc(8'h01, {8'h1a});
      rc(8'h09, {8'h00});
      wr(8'h05, {8'h8e});
      cy(50 * TICK);
      chk({7'h00, host_mode_o}, 8'h01);
      wr(8'h05, {8'h9e});
      wr(8'h01, {8'h5a});
      wr(8'h00, {8'h1f});
      wr(8'h02, {8'h85});
      cy(25 * TICK);
      chk({7'h00, host_mode_o}, 8'h01);
      cy(20 * TICK);
      chk({7'h00, host_mode_o}, 8'h00);
      rc(8'h00, {8'h1f, 8'h1a, 8'h91});
      arst_n_i <= 1'b0;
      cy(2);
      arst_n_i <= 1'b1;
      cy(4);
      rc(8'h00, {8'h17});
      finish_test();
   end
endmodule
